// ===== verilog/local_bus_consts.svh
// register offsets, field positions, reset values and counts of the bus sequencer
// assumes a 32-bit apb slave with byte addresses on word boundaries
`ifndef LOCAL_BUS_CONSTS_SVH
`define LOCAL_BUS_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_BYTEEN 8'h0c
`define OFS_STRETCH 8'h10
`define OFS_STATUS 8'h14
`define OFS_RDATA 8'h18
`define CTRL_GO 0
`define CTRL_WRITE 1
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ABORT 2
`define ST_STYLE 3
`define ST_FAST 4
`define STR_ADDR_LSB 0
`define STR_DATA_LSB 8
`define STR_GAP_LSB 16
`define STRETCH_W 8
`define RST_STRETCH 24'h000000
`define RST_BYTEEN 4'hf
`endif

// ===== verilog/local_bus_pkg.sv
// types shared by the expansion bus sequencer
// assumes the constants header alongside
package local_bus_pkg;
	typedef enum logic [3:0] {IDLE, REQ, CMD, ADDR, ALE, AHOLD, DATA, STRB, DHOLD, PARK,
		GAP} state_type;
	typedef struct packed {
		logic busRequest;
		logic grantAckN;
		logic addrStrobe;
		logic readCtl;
		logic writeCtl;
		logic [3:0] expansionByteEnables;
		logic cmdOe;
		logic [31:0] muxedAddrDataOut;
		logic muxedAddrDataOe;
	} pins_type;
endpackage : local_bus_pkg

// ===== verilog/local_bus_master_arbitration.sv
// expansion bus master: apb registers, arbitration and one read or write per go
// assumes grant and read data arrive asynchronously; style and clock select are static
// Operation
// [R1] expansion clock is host clock, or half of it when fast select is 1
// [R2] no request and no grant: every shared bus line floats
// [R3] only the external arbiter drives grant, answering our request
// [R4] latch style: byte enables and strobes valid one cycle after grant
// [R5] address driven on muxed lines two cycles after grant
// [R6] latch style: address latch strobe three cycles after request and grant
// [R7] address stretch lengthens strobe high pulse and address interval
// [R8] address stays valid one cycle after the address strobe falls
// [R9] latch style write: data one cycle before write strobe; reads float
// [R10] data stretch lengthens read, write or data strobe low pulse
// [R11] read data sampled at the edge the strobe deasserts
// [R12] latch style: write data and enables held one cycle after strobe
// [R13] latch style: request dropped and bus parked one cycle after strobe
// [R14] float one cycle after grant drop; else park until next request
// [R15] grant withdrawal floats the bus next cycle, transfer never retried
// [R16] gap stretch lengthens the request-inactive interval
// [R17] strobe style: enables, strobes and read-select valid one cycle after grant; read-select only goes low for writes two cycles after grant
// [R18] strobe style: grant acknowledge three cycles after request and grant
// [R19] strobe style write: read-select low and data one cycle before data strobe
// [R20] strobe style: data, enables, read-select held one cycle after strobe
// [R21] request dropped and bus parked one cycle after acknowledge drops
// [R22] strobe style chosen by a static input, caught at reset release
// [R23] stretch settings are unsigned counts, zero adds nothing
`timescale 1ns/1ps
`include "local_bus_consts.svh"
module local_bus_master_arbitration (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// static configuration
	input wire logic strobeStyle,
	input wire logic fastHostClockSelect,
	// expansion bus
	input wire logic arbitrationGrant,
	input wire logic [31:0] muxedAddrDataIn,
	output logic expansionClockOut,
	output local_bus_pkg::pins_type busPins
);
	// ****************************************
	// configuration and clock
	// ****************************************
	logic cfgDone_reg;
	logic style_reg;
	logic fast_reg;
	logic [1:0] div_reg;
	logic expansion_clock_out_reg;
	logic toggle;
	logic tick;
	// straps caught on the first clock after release, never by the reset itself
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfgDone_reg <= 1'b0;
			style_reg <= 1'b0;
			fast_reg <= 1'b0;
		end else if (!cfgDone_reg) begin
			cfgDone_reg <= 1'b1;
			style_reg <= strobeStyle; // R22
			fast_reg <= fastHostClockSelect;
		end
	end
	// host clock modelled as sys_clk/2, so the output stays a flop
	assign toggle = !fast_reg || div_reg[0]; // R1
	assign tick = toggle && !expansion_clock_out_reg && cfgDone_reg;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 2'h0;
			expansion_clock_out_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			// held low until the straps are in, so the first half period is never short
			expansion_clock_out_reg <= expansion_clock_out_reg ^ (toggle && cfgDone_reg); // R1
		end
	end
	assign expansionClockOut = expansion_clock_out_reg;
	// ****************************************
	// synchronisers
	// ****************************************
	logic grantMeta_reg;
	logic grantSync_reg;
	logic [31:0] dataMeta_reg;
	logic [31:0] dataSync_reg;
	logic grant;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			grantMeta_reg <= 1'b0;
			grantSync_reg <= 1'b0;
			dataMeta_reg <= 32'h0;
			dataSync_reg <= 32'h0;
		end else begin
			grantMeta_reg <= arbitrationGrant;
			grantSync_reg <= grantMeta_reg;
			dataMeta_reg <= muxedAddrDataIn;
			dataSync_reg <= dataMeta_reg;
		end
	end
	// grant polarity follows the style: high in latch style, low in strobe style
	assign grant = style_reg ? !grantSync_reg : grantSync_reg; // R3
	// ****************************************
	// registers
	// ****************************************
	logic write_reg;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [3:0] be_reg;
	logic [23:0] stretch_reg;
	logic pending_reg;
	logic done_reg;
	logic abort_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	local_bus_pkg::state_type state_reg;
	local_bus_pkg::state_type state_next;
	logic busy;
	logic setup;
	logic wrEn;
	logic mapped;
	logic goHit;
	logic clrHit;
	logic doneSet;
	logic abortSet;
	logic [7:0] addrStretch;
	logic [7:0] dataStretch;
	logic [7:0] gapStretch;
	logic [31:0] readMux;
	assign busy = pending_reg || (state_reg != local_bus_pkg::IDLE);
	assign setup = psel && !penable;
	assign wrEn = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign mapped = (paddr <= `OFS_RDATA) && (paddr[1:0] == 2'h0);
	assign goHit = wrEn && (paddr == `OFS_CTRL) && pwdata[`CTRL_GO] && !busy;
	assign clrHit = wrEn && (paddr == `OFS_STATUS);
	// R23: plain unsigned counts, zero leaves a phase at its base length
	assign addrStretch = stretch_reg[`STR_ADDR_LSB +: `STRETCH_W]; // R23
	assign dataStretch = stretch_reg[`STR_DATA_LSB +: `STRETCH_W]; // R23
	assign gapStretch = stretch_reg[`STR_GAP_LSB +: `STRETCH_W]; // R23
	assign readMux = (paddr == `OFS_CTRL) ? {30'h0, write_reg, 1'b0} :
		(paddr == `OFS_ADDR) ? addr_reg :
		(paddr == `OFS_WDATA) ? wdata_reg :
		(paddr == `OFS_BYTEEN) ? {28'h0, be_reg} :
		(paddr == `OFS_STRETCH) ? {8'h0, stretch_reg} :
		(paddr == `OFS_STATUS) ? {27'h0, fast_reg, style_reg, abort_reg, done_reg, busy} :
		rdata_reg;
	// no wait state: read data is a flop loaded in the setup cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup && !mapped;
			prdata_reg <= (setup && mapped && !pwrite) ? readMux : 32'h0;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			write_reg <= 1'b0;
			addr_reg <= 32'h0;
			wdata_reg <= 32'h0;
			be_reg <= `RST_BYTEEN;
			stretch_reg <= `RST_STRETCH;
		end else if (wrEn && !busy) begin
			if (paddr == `OFS_CTRL)
				write_reg <= pwdata[`CTRL_WRITE];
			if (paddr == `OFS_ADDR)
				addr_reg <= pwdata;
			if (paddr == `OFS_WDATA)
				wdata_reg <= pwdata;
			if (paddr == `OFS_BYTEEN)
				be_reg <= pwdata[3:0];
			if (paddr == `OFS_STRETCH)
				stretch_reg <= pwdata[23:0];
		end
	end
	// sticky flags: a hardware set wins over a write-one clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			done_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			done_reg <= doneSet || (done_reg && !(clrHit && pwdata[`ST_DONE]));
			abort_reg <= abortSet || (abort_reg && !(clrHit && pwdata[`ST_ABORT]));
		end
	end
	// ****************************************
	// sequencer
	// ****************************************
	logic owns_reg;
	logic owns_next;
	logic [7:0] cnt_reg;
	logic [7:0] gap_reg;
	logic midXfer;
	logic lost;
	logic gapDone;
	logic leaveStrb;
	logic [1:0] capture_reg;
	local_bus_pkg::pins_type pins_reg;
	local_bus_pkg::pins_type pins_next;
	assign midXfer = (state_reg >= local_bus_pkg::CMD) && (state_reg <= local_bus_pkg::DHOLD);
	assign lost = owns_reg && !grant;
	assign gapDone = gap_reg >= gapStretch; // R16
	assign leaveStrb = (state_reg == local_bus_pkg::STRB) && (cnt_reg == dataStretch);
	assign doneSet = tick && (state_reg == local_bus_pkg::DHOLD) && !lost;
	assign abortSet = tick && lost && midXfer;
	always_comb begin
		state_next = state_reg;
		owns_next = owns_reg;
		if (lost) begin
			// R15: give up the bus at once, the transfer is dropped
			state_next = local_bus_pkg::GAP; // R15
			owns_next = 1'b0; // R14
		end else begin
			unique case (state_reg)
				local_bus_pkg::IDLE: if (pending_reg) state_next = local_bus_pkg::REQ;
				local_bus_pkg::REQ: if (grant) begin
					state_next = local_bus_pkg::CMD; // R4 R17
					owns_next = 1'b1;
				end
				local_bus_pkg::CMD: state_next = local_bus_pkg::ADDR; // R5
				local_bus_pkg::ADDR: state_next = local_bus_pkg::ALE; // R6 R18
				local_bus_pkg::ALE: if (cnt_reg == addrStretch) state_next = local_bus_pkg::AHOLD; // R7
				local_bus_pkg::AHOLD: state_next = local_bus_pkg::DATA; // R8
				local_bus_pkg::DATA: state_next = local_bus_pkg::STRB; // R9 R19
				local_bus_pkg::STRB: if (leaveStrb) state_next = local_bus_pkg::DHOLD; // R10
				local_bus_pkg::DHOLD: state_next = local_bus_pkg::PARK; // R12 R20
				local_bus_pkg::PARK: if (pending_reg && gapDone) state_next = local_bus_pkg::REQ; // R14
				local_bus_pkg::GAP: if (gapDone) state_next = local_bus_pkg::IDLE; // R16
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= local_bus_pkg::IDLE;
			owns_reg <= 1'b0;
			cnt_reg <= 8'h0;
			gap_reg <= 8'h0;
		end else if (tick) begin
			state_reg <= state_next;
			owns_reg <= owns_next;
			cnt_reg <= (state_next == state_reg) ? cnt_reg + 8'h1 : 8'h0; // R7 R10
			gap_reg <= (state_next != state_reg) ? 8'h0 : (gapDone ? gap_reg : gap_reg + 8'h1);
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pending_reg <= 1'b0;
			rdata_reg <= 32'h0;
			capture_reg <= 2'h0;
		end else begin
			// pin value at the strobe edge reaches the second flop one clock later
			capture_reg <= {capture_reg[0], tick && leaveStrb && !write_reg && !lost}; // R11
			if (goHit)
				pending_reg <= 1'b1;
			else if (tick && !lost && state_next == local_bus_pkg::REQ
				&& state_reg != local_bus_pkg::REQ)
				pending_reg <= 1'b0;
			if (capture_reg[1])
				rdata_reg <= dataSync_reg; // R11
		end
	end
	// ****************************************
	// pin values, registered with the state
	// ****************************************
	logic nReq;
	logic nAddr;
	logic nData;
	logic nStrb;
	logic nAck;
	logic nRwSpan;
	assign nReq = (state_next >= local_bus_pkg::REQ) && (state_next <= local_bus_pkg::DHOLD);
	assign nAddr = (state_next >= local_bus_pkg::ADDR) && (state_next <= local_bus_pkg::AHOLD);
	assign nData = (state_next >= local_bus_pkg::DATA) && (state_next <= local_bus_pkg::DHOLD);
	assign nStrb = state_next == local_bus_pkg::STRB;
	assign nAck = (state_next >= local_bus_pkg::ALE) && (state_next <= local_bus_pkg::STRB);
	assign nRwSpan = (state_next >= local_bus_pkg::ADDR) && (state_next <= local_bus_pkg::DHOLD);
	always_comb begin
		pins_next.busRequest = style_reg ? !nReq : nReq; // R13 R21
		pins_next.grantAckN = !(style_reg && nAck); // R18 R21
		pins_next.addrStrobe = state_next == local_bus_pkg::ALE; // R6 R7
		// latch style: read strobe; strobe style: read-select, low for writes
		pins_next.readCtl = style_reg ? !(nRwSpan && write_reg) : !(nStrb && !write_reg); // R19
		pins_next.writeCtl = style_reg ? !nStrb : !(nStrb && write_reg); // R9 R10
		pins_next.expansionByteEnables = be_reg;
		pins_next.cmdOe = owns_next; // R2 R14 R15
		pins_next.muxedAddrDataOut = nAddr ? addr_reg : (nData ? wdata_reg : 32'h0);
		pins_next.muxedAddrDataOe = owns_next && (nAddr || (nData && write_reg)); // R9 R13
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			pins_reg <= '{busRequest: 1'b0, grantAckN: 1'b1, readCtl: 1'b1, writeCtl: 1'b1,
				expansionByteEnables: 4'h0, muxedAddrDataOut: 32'h0, default: 1'b0};
		else if (tick)
			pins_reg <= pins_next;
	end
	assign busPins = pins_reg;
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_idle_floats: assert property (state_reg == local_bus_pkg::IDLE |-> !pins_reg.cmdOe
		&& !pins_reg.muxedAddrDataOe) else $error("bus driven while idle"); // R2
	a_expansion_clock_out_full_rate: assert property (cfgDone_reg && !fast_reg |=> expansion_clock_out_reg != $past(expansion_clock_out_reg))
		else $error("expansion clock not toggling each cycle"); // R1
	a_cmd_one_after: assert property (state_reg == local_bus_pkg::CMD |-> pins_reg.cmdOe
		&& !pins_reg.muxedAddrDataOe) else $error("command lines not driven"); // R4
	a_addr_two_after: assert property (state_reg == local_bus_pkg::ADDR |->
		pins_reg.muxedAddrDataOe && pins_reg.muxedAddrDataOut == addr_reg)
		else $error("address not driven"); // R5
	a_strobe_third: assert property ($rose(state_reg == local_bus_pkg::ALE) |->
		pins_reg.addrStrobe && $past(state_reg) == local_bus_pkg::ADDR)
		else $error("address strobe out of place"); // R6
	a_ack_third: assert property (style_reg && state_reg == local_bus_pkg::ALE |->
		!pins_reg.grantAckN) else $error("grant acknowledge missing"); // R18
	a_addr_hold: assert property (state_reg == local_bus_pkg::AHOLD |-> !pins_reg.addrStrobe
		&& pins_reg.muxedAddrDataOut == addr_reg) else $error("address not held"); // R8
	a_wdata_early: assert property (state_reg == local_bus_pkg::DATA && write_reg |->
		pins_reg.muxedAddrDataOut == wdata_reg && pins_reg.writeCtl)
		else $error("write data not ahead of strobe"); // R9
	a_read_floats: assert property (nData && !write_reg && tick |=> !pins_reg.muxedAddrDataOe)
		else $error("data lines driven during read"); // R9
	a_park_state: assert property (state_reg == local_bus_pkg::PARK |-> pins_reg.cmdOe
		&& !pins_reg.muxedAddrDataOe && pins_reg.busRequest == style_reg)
		else $error("bus not parked"); // R13
	a_abort_float: assert property (tick && lost |=> !pins_reg.cmdOe
		&& state_reg == local_bus_pkg::GAP) else $error("bus kept after grant loss"); // R15
	a_gap_holds_off: assert property (tick && state_reg == local_bus_pkg::GAP && !gapDone |=>
		state_reg == local_bus_pkg::GAP) else $error("request gap cut short"); // R16
	c_write_done: cover property (doneSet && write_reg);
	c_read_done: cover property (doneSet && !write_reg);
	c_abort: cover property (abortSet);
	c_park_reuse: cover property (tick && state_reg == local_bus_pkg::PARK
		&& state_next == local_bus_pkg::REQ);
endmodule : local_bus_master_arbitration

// ===== tb/bus_partner_model.sv
// far side of the expansion bus: one arbiter and one peripheral
// assumes the pin struct of the sequencer; grant polarity follows the strobe style
`timescale 1ns/1ps
module bus_partner_model (
	// clock and style
	input wire logic sys_clk,
	input wire logic strobeStyle,
	// bench controls
	input wire logic [3:0] grantDelay,
	input wire logic dropGrant,
	input wire logic [31:0] readWord,
	// expansion bus
	input wire local_bus_pkg::pins_type busPins,
	output logic arbitrationGrant,
	output logic [31:0] muxedAddrDataIn
);
	logic reqOn;
	logic readStrobe;
	logic grantOn = 1'h0;
	logic [3:0] waitCnt = 4'h0;
	logic [1:0] holdCnt = 2'h0;
	logic [31:0] idleWord = 32'h5a5a_a5a5;
	assign reqOn = strobeStyle ? !busPins.busRequest : busPins.busRequest;
	assign readStrobe = busPins.cmdOe &&
		(strobeStyle ? busPins.readCtl && !busPins.writeCtl : !busPins.readCtl);
	// grant only ever answers a request; delay lets the bench be slow or prompt
	always @(posedge sys_clk) begin
		if (dropGrant || !reqOn) begin
			grantOn <= 1'h0;
			waitCnt <= 4'h0;
		end else if (waitCnt >= grantDelay) begin
			grantOn <= 1'h1;
		end else begin
			waitCnt <= waitCnt + 4'h1;
		end
	end
	// data held past the strobe, the sequencer samples through a synchroniser
	always @(posedge sys_clk) begin
		idleWord <= ~idleWord;
		if (readStrobe)
			holdCnt <= 2'h3;
		else if (holdCnt != 2'h0)
			holdCnt <= holdCnt - 2'h1;
	end
	// released lines show a toggling pattern, never a stale word
	assign muxedAddrDataIn = (readStrobe || holdCnt != 2'h0) ? readWord : idleWord;
	assign arbitrationGrant = strobeStyle ? !grantOn : grantOn;
endmodule : bus_partner_model

// ===== tb/local_bus_master_arbitration_tb_top.sv
// bench for the expansion bus sequencer, both strobe styles and clock selects
// assumes the apb map of the constants header and the partner model
`timescale 1ns/1ps
`include "local_bus_consts.svh"
module local_bus_master_arbitration_tb_top;
	// ****
	// signals and tasks
	// ****
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic strobeStyle = 1'h0;
	logic fastHostClockSelect = 1'h0;
	logic [3:0] grantDelay = 4'h0;
	logic dropGrant = 1'h0;
	logic [31:0] readWord = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic arbitrationGrant;
	logic [31:0] muxedAddrDataIn;
	logic expansionClockOut;
	local_bus_pkg::pins_type busPins;
	logic [32:0] expQ[$];
	logic [32:0] mskQ[$];
	int mismatches = 0;
	int testsRun = 0;
	initial forever #12.5 sys_clk = ~sys_clk;
	local_bus_master_arbitration u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strobeStyle(strobeStyle),
		.fastHostClockSelect(fastHostClockSelect), .arbitrationGrant(arbitrationGrant),
		.muxedAddrDataIn(muxedAddrDataIn), .expansionClockOut(expansionClockOut),
		.busPins(busPins));
	bus_partner_model u_partner (.sys_clk(sys_clk), .strobeStyle(strobeStyle),
		.grantDelay(grantDelay), .dropGrant(dropGrant), .readWord(readWord),
		.busPins(busPins), .arbitrationGrant(arbitrationGrant),
		.muxedAddrDataIn(muxedAddrDataIn));
	task automatic endSim;
		$display("comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : endSim
	task automatic checkWord(input string what, input logic [32:0] exp, input logic [32:0] got);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : checkWord
	// read results are matched against the oldest note, masked to the bits that matter
	always @(posedge sys_clk) begin : apbMon
		logic [32:0] e;
		logic [32:0] m;
		if (psel && penable && pready === 1'h1 && !pwrite) begin
			e = expQ.pop_front();
			m = mskQ.pop_front();
			checkWord("apb read", e & m, {pslverr, prdata} & m);
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		int i;
		if (!wr) begin
			expQ.push_back(e);
			mskQ.push_back(m);
		end
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'h1 && i < 50);
		if (i >= 50) begin
			mismatches++;
			endSim();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	function automatic logic reqOn();
		return strobeStyle ? !busPins.busRequest : busPins.busRequest;
	endfunction : reqOn
	function automatic logic strobeOn();
		return busPins.cmdOe && !(strobeStyle ? busPins.writeCtl : busPins.readCtl && busPins.writeCtl);
	endfunction : strobeOn
	// free-running design clock, so one step is bounded by the watchdog only
	task automatic eclkStep;
		@(posedge expansionClockOut);
		#1;
	endtask : eclkStep
	task automatic runXfer(input logic wr, input logic [7:0] as, input logic [7:0] ds);
		logic [31:0] a;
		logic [31:0] d;
		logic [3:0] be;
		logic [32:0] cur;
		logic [32:0] prev;
		int k;
		int cmd0;
		int ale0;
		int ale1;
		int st0;
		int st1;
		a = $urandom;
		d = $urandom;
		be = 4'($urandom);
		{cmd0, ale0, ale1, st0, st1} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, -32'sd1};
		prev = 33'h0;
		@(posedge sys_clk);
		readWord <= $urandom;
		grantDelay <= 4'($urandom_range(5));
		apb(1'h1, `OFS_ADDR, a, 33'h0, 33'h0);
		apb(1'h1, `OFS_WDATA, d, 33'h0, 33'h0);
		apb(1'h1, `OFS_BYTEEN, {28'h0, be}, 33'h0, 33'h0);
		apb(1'h1, `OFS_STRETCH, {16'h0, ds, as}, 33'h0, 33'h0);
		apb(1'h1, `OFS_CTRL, {30'h0, wr, 1'h1}, 33'h0, 33'h0);
		for (k = 0; k < 200 && !(st1 >= 0 && k > st1 + 2); k++) begin
			eclkStep();
			cur = {busPins.muxedAddrDataOe, busPins.muxedAddrDataOut};
			if (cmd0 < 0 && busPins.cmdOe) begin
				cmd0 = k;
				checkWord("enables at command", 33'(be), 33'(busPins.expansionByteEnables));
			end
			if (cmd0 >= 0 && k == cmd0 + 1)
				checkWord("address out", {1'h1, a}, cur);
			if (busPins.cmdOe && busPins.addrStrobe) begin
				if (ale0 < 0)
					ale0 = k;
				ale1 = k;
			end
			if (ale1 >= 0 && k == ale1 + 1)
				checkWord("address hold", {1'h1, a}, cur);
			if (strobeOn() && st0 < 0) begin
				st0 = k;
				checkWord("data lead", {wr, wr ? d : 32'h0}, {prev[32], wr ? prev[31:0] : 32'h0});
				if (strobeStyle)
					checkWord("read select", 33'(!wr), 33'(busPins.readCtl));
			end
			if (strobeOn())
				st1 = k;
			if (st1 >= 0 && k == st1 + 1) begin
				checkWord("strobe width", 33'(1 + ds), 33'(st1 - st0 + 1));
				checkWord("held enables", 33'(be), 33'(busPins.expansionByteEnables));
				if (wr)
					checkWord("held data", {1'h1, d}, cur);
			end
			if (st1 >= 0 && k == st1 + 2)
				checkWord("park", 33'h2, {reqOn(), busPins.cmdOe, busPins.muxedAddrDataOe});
			prev = cur;
		end
		if (k >= 200) begin
			mismatches++;
			endSim();
		end
		checkWord("strobe lead", 33'(cmd0 + 2), 33'(ale0));
		checkWord("strobe high width", 33'(1 + as), 33'(ale1 - ale0 + 1));
		// busy stays up through park and gap; wait for the grant drop and the gap
		for (k = 0; k < 20 && busPins.cmdOe; k++)
			eclkStep();
		if (k >= 20) begin
			mismatches++;
			endSim();
		end
		repeat (2) eclkStep();
		apb(1'h0, `OFS_STATUS, 32'h0, 33'h2, 33'h7);
		if (!wr)
			apb(1'h0, `OFS_RDATA, 32'h0, {1'h0, readWord}, 33'h1_ffff_ffff);
		apb(1'h1, `OFS_STATUS, 32'h6, 33'h0, 33'h0);
	endtask : runXfer
	task automatic abortXfer;
		int k;
		apb(1'h1, `OFS_STRETCH, 32'h0002_0606, 33'h0, 33'h0);
		apb(1'h1, `OFS_CTRL, 32'h3, 33'h0, 33'h0);
		for (k = 0; k < 100 && !(busPins.cmdOe && busPins.addrStrobe); k++)
			eclkStep();
		if (k >= 100) begin
			mismatches++;
			endSim();
		end
		@(posedge sys_clk);
		dropGrant <= 1'h1;
		repeat (3) eclkStep();
		checkWord("abort float", 33'h0, {reqOn(), busPins.cmdOe, busPins.muxedAddrDataOe});
		@(posedge sys_clk);
		dropGrant <= 1'h0;
		repeat (12) begin
			eclkStep();
			checkWord("no retry", 33'h0, 33'(reqOn()));
		end
		apb(1'h0, `OFS_STATUS, 32'h0, 33'h4, 33'h7);
		apb(1'h1, `OFS_STATUS, 32'h6, 33'h0, 33'h0);
	endtask : abortXfer
	// ****
	// main sequence
	// ****
	initial begin
		#2_000_000;
		mismatches++;
		endSim();
	end
	initial begin
		int cfg;
		realtime t0;
		void'($urandom(32'h922d));
		for (cfg = 0; cfg < 2; cfg++) begin
			@(posedge sys_clk);
			nrst <= 1'h0;
			strobeStyle <= cfg[0];
			fastHostClockSelect <= cfg[0];
			repeat (20) @(posedge sys_clk);
			nrst <= 1'h1;
			eclkStep();
			t0 = $realtime;
			eclkStep();
			checkWord("expansion_clock_out period", 33'(cfg ? 100 : 50), 33'(int'($realtime - t0)));
			checkWord("idle float", 33'h0, {reqOn(), busPins.cmdOe, busPins.muxedAddrDataOe});
			apb(1'h0, `OFS_STATUS, 32'h0, 33'(cfg * 24), 33'h1f);
			apb(1'h0, `OFS_STRETCH, 32'h0, 33'h0, 33'h1_ffff_ffff);
			apb(1'h0, `OFS_BYTEEN, 32'h0, 33'hf, 33'h1_ffff_ffff);
			apb(1'h0, 8'h1c, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
			runXfer(1'h1, 8'($urandom_range(3)), 8'($urandom_range(3)));
			runXfer(1'h0, 8'($urandom_range(3)), 8'($urandom_range(3)));
			runXfer(1'h1, 8'h0, 8'h0);
			abortXfer();
		end
		endSim();
	end
endmodule : local_bus_master_arbitration_tb_top
